// File: core/sfm_core.sv
// Sample FIFO with mode control and the 24-bit reference pressure registers.
// Assumes the serial host interface hands over byte register accesses on
// sys_clk_i, and that samples, trigger and autozero strobes come from logic
// on the same clock.
`timescale 1ns/100ps
`include "sfm_params.svh"

// ----------------------------------------------------------------------------
// Sample store
// ----------------------------------------------------------------------------
// DEPTH must be a power of two so that the pointers wrap by themselves.
module sfm_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic flush_i,
	input wire logic ovw_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	output logic [AW:0] level_o,
	output logic full_o,
	output logic drop_o
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr;
	logic [AW:0] count, next_count;
	logic push, out_pop, pop;
	// Handshake decode; a full store only takes a word when overwrite is on
	assign full_o = (count == (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign in_ready_o = !full_o || ovw_i;
	assign push = in_valid_i && in_ready_o && !flush_i;
	assign out_pop = out_valid_o && out_ready_i && !flush_i;
	assign drop_o = push && full_o && !out_pop;
	assign pop = out_pop || drop_o;
	assign out_data_o = mem[rd_ptr];
	assign level_o = count;
	assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

	// Storage words have no reset; only the pointers and the fill count need one
	always_ff @(posedge sys_clk_i)
	begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end

	// Pointers and fill count; a flush wins over any transfer in that cycle
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i || flush_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			wr_ptr <= wr_ptr + AW'(push);
			rd_ptr <= rd_ptr + AW'(pop);
			count <= next_count;
		end
	end
endmodule

// ----------------------------------------------------------------------------
// Control, reference and mode logic
// ----------------------------------------------------------------------------
module sfm_core #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic smp_valid_i,
	output logic smp_ready_o,
	input wire logic [WIDTH-1:0] smp_pressure_i,
	input wire logic trig_i,
	input wire logic az_capture_i,
	input wire logic autozero_clear_bit_i,
	input wire logic [WIDTH-1:0] limit_i,
	output logic [WIDTH-1:0] press_o,
	output logic p_high_o,
	output logic p_low_o,
	output logic fifo_valid_o,
	input wire logic fifo_ready_i,
	output logic [WIDTH-1:0] fifo_data_o,
	output logic [$clog2(DEPTH):0] fifo_level_o,
	output logic fifo_full_o,
	output logic watermark_o,
	output logic overrun_flag_o
);
	logic [7:0] fifo_control, rd_mux;
	logic [WIDTH-1:0] ref_press, sum_press;
	logic trig_q, trig_fell, az_pend, flush_q;
	sfm_pkg::sfm_mode_t mode;
	sfm_pkg::sfm_beh_t beh;
	logic wr_ctrl, wr_low, wr_mid, wr_high;
	logic flush, ovw, fifo_in_valid, fifo_in_ready, fifo_drop;
	logic signed [WIDTH:0] diff_press, lim_pos;
	// Register write decode
	assign wr_ctrl = reg_wr_i && (reg_addr_i == `SFM_ADDR_CONTROL);
	assign wr_low = reg_wr_i && (reg_addr_i == `SFM_ADDR_REF_LOW);
	assign wr_mid = reg_wr_i && (reg_addr_i == `SFM_ADDR_REF_MID);
	assign wr_high = reg_wr_i && (reg_addr_i == `SFM_ADDR_REF_HIGH);
	// Mode field; the watermark sits in the low field
	assign mode = sfm_pkg::sfm_mode_t'(fifo_control[`SFM_MODE_HI:`SFM_MODE_LO]);
	// Behaviour chosen from mode and the trigger history
	always_comb
	begin
		case (mode)
			sfm_pkg::SFM_MODE_BYPASS: beh = sfm_pkg::SFM_BEH_BYPASS;
			sfm_pkg::SFM_MODE_FIFO: beh = sfm_pkg::SFM_BEH_FIFO;
			sfm_pkg::SFM_MODE_STREAM: beh = sfm_pkg::SFM_BEH_STREAM;
			sfm_pkg::SFM_MODE_STR2FIFO:
				beh = trig_fell ? sfm_pkg::SFM_BEH_FIFO : sfm_pkg::SFM_BEH_STREAM;
			sfm_pkg::SFM_MODE_BYP2STR:
				beh = trig_fell ? sfm_pkg::SFM_BEH_STREAM : sfm_pkg::SFM_BEH_BYPASS;
			sfm_pkg::SFM_MODE_DYNSTREAM: beh = sfm_pkg::SFM_BEH_STREAM;
			sfm_pkg::SFM_MODE_BYP2FIFO:
				beh = trig_fell ? sfm_pkg::SFM_BEH_FIFO : sfm_pkg::SFM_BEH_BYPASS;
			default: beh = sfm_pkg::SFM_BEH_BYPASS;
		endcase
	end
	// Bypass keeps the store empty; stream lets a full store overwrite
	assign flush = (beh == sfm_pkg::SFM_BEH_BYPASS);
	assign ovw = (beh == sfm_pkg::SFM_BEH_STREAM);
	assign fifo_in_valid = smp_valid_i && !flush;
	// In FIFO mode a full store stalls the sample source
	assign smp_ready_o = flush || fifo_in_ready;
	// Pressure arithmetic on the incoming sample
	assign sum_press = smp_pressure_i + ref_press;
	assign diff_press = $signed({smp_pressure_i[WIDTH-1], smp_pressure_i})
		- $signed({ref_press[WIDTH-1], ref_press});
	assign lim_pos = $signed({1'b0, limit_i});

	// Trigger edge and flush history; a control write restarts the triggered sequence
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			trig_q <= 1'b0;
			trig_fell <= 1'b0;
			flush_q <= 1'b0;
		end
		else
		begin
			flush_q <= flush;
			trig_q <= trig_i;
			if (wr_ctrl)
				trig_fell <= 1'b0;
			else if (trig_q && !trig_i)
				trig_fell <= 1'b1;
		end
	end

	// Control register; host write only
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			fifo_control <= `SFM_RST_BYTE;
		else if (wr_ctrl)
			fifo_control <= reg_wdata_i;
	end

	// Reference bytes; autozero capture lands after a host write of the same cycle
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			ref_press <= `SFM_RST_REF;
			az_pend <= 1'b0;
		end
		else if (autozero_clear_bit_i)
		begin
			ref_press <= `SFM_RST_REF;
			az_pend <= 1'b0;
		end
		else
		begin
			if (wr_low)
				ref_press[`SFM_REF_LOW_HI:`SFM_REF_LOW_LO] <= reg_wdata_i;
			if (wr_mid)
				ref_press[`SFM_REF_MID_HI:`SFM_REF_MID_LO] <= reg_wdata_i;
			if (wr_high)
				ref_press[`SFM_REF_HIGH_HI:`SFM_REF_HIGH_LO] <= reg_wdata_i;
			if (az_pend && smp_valid_i)
			begin
				ref_press <= smp_pressure_i;
				az_pend <= 1'b0;
			end
			else if (az_capture_i)
				az_pend <= 1'b1;
		end
	end

	// Output pressure and limit flags, refreshed with each sample
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			press_o <= '0;
			p_high_o <= 1'b0;
			p_low_o <= 1'b0;
		end
		else if (smp_valid_i)
		begin
			press_o <= sum_press;
			p_high_o <= (diff_press > lim_pos);
			p_low_o <= (diff_press < -lim_pos);
		end
	end

	// Overrun is sticky until bypass empties the store; a new drop wins
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			overrun_flag_o <= 1'b0;
		else if (fifo_drop)
			overrun_flag_o <= 1'b1;
		else if (flush)
			overrun_flag_o <= 1'b0;
	end

	// Read multiplexer; unmapped addresses read zero
	assign rd_mux = (reg_addr_i == `SFM_ADDR_CONTROL) ? fifo_control
		: (reg_addr_i == `SFM_ADDR_REF_LOW) ? ref_press[`SFM_REF_LOW_HI:`SFM_REF_LOW_LO]
		: (reg_addr_i == `SFM_ADDR_REF_MID) ? ref_press[`SFM_REF_MID_HI:`SFM_REF_MID_LO]
		: (reg_addr_i == `SFM_ADDR_REF_HIGH) ? ref_press[`SFM_REF_HIGH_HI:`SFM_REF_HIGH_LO]
		: `SFM_READ_ZERO;

	// Read data registered, one cycle after the strobe
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			reg_rdata_o <= `SFM_READ_ZERO;
		else if (reg_rd_i)
			reg_rdata_o <= rd_mux;
	end

	// Watermark compare against the fill level
	assign watermark_o = (fifo_level_o >= ($clog2(DEPTH)+1)'(
		fifo_control[`SFM_WTM_HI:`SFM_WTM_LO]));

	sfm_fifo #(
		.WIDTH(WIDTH),
		.DEPTH(DEPTH)
	) u_store (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.flush_i(flush),
		.ovw_i(ovw),
		.in_valid_i(fifo_in_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(sum_press),
		.out_valid_o(fifo_valid_o),
		.out_ready_i(fifo_ready_i),
		.out_data_o(fifo_data_o),
		.level_o(fifo_level_o),
		.full_o(fifo_full_o),
		.drop_o(fifo_drop)
	);

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	bypass_empties_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		flush_q |-> (fifo_level_o == '0) && !fifo_valid_o)
		else $error("store not empty in bypass");
	fifo_full_stalls_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(beh == sfm_pkg::SFM_BEH_FIFO) && fifo_full_o |-> !smp_ready_o)
		else $error("full store in FIFO mode still takes samples");
	stream_overwrite_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ovw && fifo_full_o && smp_valid_i && !fifo_ready_i
		|=> fifo_full_o && overrun_flag_o)
		else $error("stream overwrite did not keep store full or flag overrun");
	trig_stream_fifo_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(mode == sfm_pkg::SFM_MODE_STR2FIFO) && trig_q && !trig_i && !wr_ctrl
		|=> (beh == sfm_pkg::SFM_BEH_FIFO))
		else $error("stream-to-FIFO did not switch after trigger fall");
	trig_bypass_stream_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(mode == sfm_pkg::SFM_MODE_BYP2STR) && !trig_fell |-> flush ##1 (fifo_level_o == '0))
		else $error("bypass-to-stream stored before trigger fall");
	trig_bypass_fifo_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(mode == sfm_pkg::SFM_MODE_BYP2FIFO) && trig_fell && !wr_ctrl
		|=> (beh == sfm_pkg::SFM_BEH_FIFO))
		else $error("bypass-to-FIFO left FIFO behaviour");
	ref_high_byte_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_high && !autozero_clear_bit_i && !(az_pend && smp_valid_i)
		|=> ref_press[`SFM_REF_HIGH_HI:`SFM_REF_HIGH_LO] == $past(reg_wdata_i))
		else $error("high reference byte not stored");
	press_sum_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		smp_valid_i |=> press_o == $past(smp_pressure_i) + $past(ref_press))
		else $error("output pressure is not sample plus reference");
	autozero_clear_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		autozero_clear_bit_i |=> (ref_press == '0) && !az_pend)
		else $error("autozero clear left a reference");
	reserved_bypass_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(mode == sfm_pkg::SFM_MODE_RESERVED) |-> flush && smp_ready_o)
		else $error("reserved mode not treated as bypass");
	readback_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		reg_rd_i && (reg_addr_i == `SFM_ADDR_CONTROL) |=> reg_rdata_o == $past(fifo_control))
		else $error("control register read back wrong");
endmodule

// File: pkg/sfm_params.svh
// Register map, field positions and reset values of the sample FIFO control
// block. Assumes inclusion by bare name from the design files.
`ifndef SFM_PARAMS_SVH
`define SFM_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define SFM_ADDR_CONTROL 8'h14
`define SFM_ADDR_REF_LOW 8'h15
`define SFM_ADDR_REF_MID 8'h16
`define SFM_ADDR_REF_HIGH 8'h17

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define SFM_MODE_HI 7
`define SFM_MODE_LO 5
`define SFM_WTM_HI 4
`define SFM_WTM_LO 0
`define SFM_REF_LOW_HI 7
`define SFM_REF_LOW_LO 0
`define SFM_REF_MID_HI 15
`define SFM_REF_MID_LO 8
`define SFM_REF_HIGH_HI 23
`define SFM_REF_HIGH_LO 16
`define SFM_RST_BYTE 8'h00
`define SFM_RST_REF 24'h000000
`define SFM_READ_ZERO 8'h00

`endif

// File: pkg/sfm_pkg.sv
// Types shared by the sample FIFO control block.
// Assumes nothing of its surroundings.
package sfm_pkg;

	// Mode codes held in the control register
	typedef enum logic [2:0]
	{
		SFM_MODE_BYPASS = 3'b000,
		SFM_MODE_FIFO = 3'b001,
		SFM_MODE_STREAM = 3'b010,
		SFM_MODE_STR2FIFO = 3'b011,
		SFM_MODE_BYP2STR = 3'b100,
		SFM_MODE_RESERVED = 3'b101,
		SFM_MODE_DYNSTREAM = 3'b110,
		SFM_MODE_BYP2FIFO = 3'b111
	} sfm_mode_t;

	// Behaviour that the storage follows at a given moment
	typedef enum logic [1:0]
	{
		SFM_BEH_BYPASS = 2'b00,
		SFM_BEH_FIFO = 2'b01,
		SFM_BEH_STREAM = 2'b10
	} sfm_beh_t;

endpackage

// File: test/sfm_host_model.sv
// Host processor model that issues byte register accesses to the block.
// Assumes one clock shared with the block and a bus without wait states.
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// Host access model
// ----------------------------------------------------------------------------
module sfm_host_model (
	input wire logic sys_clk_i,
	output logic [7:0] reg_addr_o,
	output logic reg_wr_o,
	output logic [7:0] reg_wdata_o,
	output logic reg_rd_o,
	input wire logic [7:0] reg_rdata_i
);
	// Bus starts idle
	initial
	begin
		reg_addr_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_wdata_o = 8'h00;
		reg_rd_o = 1'b0;
	end

	// One-cycle write strobe, then one idle edge so a following strobe never toggles
	// in the same step; idle lines show inverted values so stale data never passes
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		reg_addr_o = addr;
		reg_wdata_o = data;
		reg_wr_o = 1'b1;
		@(posedge sys_clk_i);
		#1;
		reg_wr_o = 1'b0;
		reg_addr_o = ~reg_addr_o;
		reg_wdata_o = ~reg_wdata_o;
		@(posedge sys_clk_i);
		#1;
	endtask

	// One-cycle read strobe and one idle edge; data is registered at the taking edge
	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		reg_addr_o = addr;
		reg_rd_o = 1'b1;
		@(posedge sys_clk_i);
		#1;
		reg_rd_o = 1'b0;
		reg_addr_o = ~reg_addr_o;
		data = reg_rdata_i;
		@(posedge sys_clk_i);
		#1;
	endtask
endmodule

// File: test/sfm_core_tb_top.sv
// Self-checking bench for the sample FIFO control block.
// Assumes the host model drives the register bus; inputs change 1 ns after the edge.
`timescale 1ns/100ps
`include "sfm_params.svh"

// ----------------------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------------------
module sfm_core_tb_top;
	logic sys_clk_i, rst_i, reg_wr_i, reg_rd_i, smp_valid_i, smp_ready_o, trig_i;
	logic az_capture_i, autozero_clear_bit_i, p_high_o, p_low_o, fifo_valid_o, fifo_ready_i;
	logic fifo_full_o, watermark_o, overrun_flag_o;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rd_byte;
	logic [23:0] smp_pressure_i, limit_i, press_o, fifo_data_o;
	logic [5:0] fifo_level_o;
	int err_total, n_checks, cyc, k;
	logic [7:0] trig_mode [3] = '{8'h60, 8'h80, 8'he0};
	logic [23:0] ovr_before [3] = '{24'h1, 24'h0, 24'h0};
	logic [23:0] rdy_after [3] = '{24'h0, 24'h1, 24'h0};

	sfm_core #(.WIDTH(24), .DEPTH(32)) u_dut (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wr_i,
		.reg_wdata_i, .reg_rd_i, .reg_rdata_o, .smp_valid_i, .smp_ready_o, .smp_pressure_i,
		.trig_i, .az_capture_i, .autozero_clear_bit_i, .limit_i, .press_o, .p_high_o, .p_low_o,
		.fifo_valid_o, .fifo_ready_i, .fifo_data_o, .fifo_level_o, .fifo_full_o, .watermark_o,
		.overrun_flag_o);

	sfm_host_model u_host (.sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
		.reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o));

	// Clock and a ceiling several times the three hundred and thirty or so cycles the tests need
	initial sys_clk_i = 1'b0;
	always #10 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			err_total++;
			complete_run();
		end
	end

	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp, input string what);
		u_host.rd(addr, rd_byte);
		chk(what, {16'h0, rd_byte}, {16'h0, exp});
	endtask

	task automatic idle(input int n);
		repeat (n)
		begin
			@(posedge sys_clk_i);
			#1;
		end
	endtask

	// Valid stays high across a burst and an idle edge follows, so it never toggles in one step
	task automatic push_n(input int n, input logic [23:0] base);
		int i;
		smp_valid_i = 1'b1;
		for (i = 0; i < n; i++)
		begin
			smp_pressure_i = base + 24'(i);
			idle(1);
		end
		smp_valid_i = 1'b0;
		smp_pressure_i = ~smp_pressure_i;
		idle(1);
	endtask

	task automatic lvl(input logic [23:0] exp);
		chk("level", {18'h0, fifo_level_o}, exp);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		{rst_i, smp_valid_i, trig_i, az_capture_i, autozero_clear_bit_i, fifo_ready_i} = 6'h20;
		smp_pressure_i = 24'h0;
		limit_i = 24'h000010;
		repeat (2) @(posedge sys_clk_i);
		#1;
		rst_i = 1'b0;
		for (k = 0; k < 4; k++) rdchk(8'h14 + 8'(k), `SFM_RST_BYTE, "reset value");
		u_host.wr(`SFM_ADDR_REF_LOW, 8'h56);
		u_host.wr(`SFM_ADDR_REF_MID, 8'h34);
		u_host.wr(`SFM_ADDR_REF_HIGH, 8'h12);
		rdchk(`SFM_ADDR_REF_LOW, 8'h56, "ref low");
		rdchk(`SFM_ADDR_REF_MID, 8'h34, "ref mid");
		rdchk(`SFM_ADDR_REF_HIGH, 8'h12, "ref high");
		rdchk(8'h20, 8'h00, "unmapped");
		$display("test registers done");
		// Far below the reference trips the low limit, just above trips the high one
		push_n(1, 24'h000100);
		chk("press", press_o, 24'h123556);
		chk("flags", {22'h0, p_high_o, p_low_o}, 24'h1);
		push_n(1, 24'h123500);
		chk("press", press_o, 24'h246956);
		chk("flags", {22'h0, p_high_o, p_low_o}, 24'h2);
		lvl(24'd0);
		$display("test reference done");
		u_host.wr(`SFM_ADDR_CONTROL, 8'h3f);
		rdchk(`SFM_ADDR_CONTROL, 8'h3f, "control");
		push_n(30, 24'h0);
		chk("watermark", {23'h0, watermark_o}, 24'h0);
		chk("valid", {23'h0, fifo_valid_o}, 24'h1);
		push_n(3, 24'h00001e);
		lvl(24'd32);
		chk("full", {23'h0, fifo_full_o}, 24'h1);
		chk("ready", {23'h0, smp_ready_o}, 24'h0);
		chk("watermark", {23'h0, watermark_o}, 24'h1);
		// Stored words are the sample plus the reference 123456
		chk("head", fifo_data_o, 24'h123456);
		fifo_ready_i = 1'b1;
		idle(1);
		fifo_ready_i = 1'b0;
		chk("head", fifo_data_o, 24'h123457);
		chk("full", {23'h0, fifo_full_o}, 24'h0);
		$display("test fifo mode done");
		u_host.wr(`SFM_ADDR_CONTROL, 8'h40);
		push_n(2, 24'h000040);
		lvl(24'd32);
		chk("head", fifo_data_o, 24'h123458);
		chk("overrun", {23'h0, overrun_flag_o}, 24'h1);
		u_host.wr(`SFM_ADDR_CONTROL, 8'hc0);
		push_n(1, 24'h000050);
		chk("head", fifo_data_o, 24'h123459);
		u_host.wr(`SFM_ADDR_CONTROL, 8'h00);
		idle(1);
		lvl(24'd0);
		chk("valid", {23'h0, fifo_valid_o}, 24'h0);
		chk("overrun", {23'h0, overrun_flag_o}, 24'h0);
		u_host.wr(`SFM_ADDR_CONTROL, 8'ha0);
		push_n(1, 24'h000060);
		idle(1);
		lvl(24'd0);
		$display("test stream and bypass done");
		// Each triggered mode: behaviour before and after the trigger falls
		for (k = 0; k < 3; k++)
		begin
			u_host.wr(`SFM_ADDR_CONTROL, 8'h00);
			idle(1);
			trig_i = 1'b1;
			u_host.wr(`SFM_ADDR_CONTROL, trig_mode[k]);
			push_n(33, 24'h000100);
			lvl(ovr_before[k] == 24'h1 ? 24'd32 : 24'd0);
			chk("overrun", {23'h0, overrun_flag_o}, ovr_before[k]);
			trig_i = 1'b0;
			idle(3);
			push_n(33, 24'h000200);
			lvl(24'd32);
			chk("ready", {23'h0, smp_ready_o}, rdy_after[k]);
		end
		$display("test triggered modes done");
		u_host.wr(`SFM_ADDR_CONTROL, 8'h00);
		az_capture_i = 1'b1;
		idle(1);
		az_capture_i = 1'b0;
		push_n(1, 24'h000777);
		rdchk(`SFM_ADDR_REF_LOW, 8'h77, "captured low");
		rdchk(`SFM_ADDR_REF_MID, 8'h07, "captured mid");
		rdchk(`SFM_ADDR_REF_HIGH, 8'h00, "captured high");
		autozero_clear_bit_i = 1'b1;
		idle(1);
		autozero_clear_bit_i = 1'b0;
		rdchk(`SFM_ADDR_REF_LOW, 8'h00, "cleared low");
		$display("test autozero done");
		complete_run();
	end
endmodule
